// *** rtc_backup_pkg.sv ***
// Package holding offsets, reset values and field layouts of the RTC backup register bank.
// Assumes a 32-bit AHB-Lite slave with one aligned word per register.
package rtc_backup_pkg;

  // Printed offsets are register indices; byte address is four times the index.
  localparam logic [7:0]  TRIM_IDX        = 8'h15;
  localparam logic [7:0]  CFG_VALID_IDX   = 8'h16;
  localparam logic [7:0]  SCRATCH_ONE_IDX = 8'h17;
  localparam logic [7:0]  SCRATCH_TWO_IDX = 8'h18;
  localparam logic [7:0]  IRQ_STATUS_IDX  = 8'h20;
  localparam logic [7:0]  IRQ_MASK_IDX    = 8'h21;
  localparam logic [7:0]  EVENT_IDX       = 8'h22;

  localparam int          TRIM_WIDTH      = 6;
  localparam int          SCRATCH_WIDTH   = 8;
  localparam int          CFG_VALID_BIT   = 0;
  localparam int          EVENT_COUNT     = 3;

  localparam logic [5:0]  TRIM_RESET      = 6'h27;
  localparam logic [7:0]  SCRATCH_RESET   = 8'h00;
  localparam logic        CFG_RESET       = 1'b0;
  localparam logic [2:0]  IRQ_RESET       = 3'h0;

  // Event bit positions in the status and mask registers.
  localparam int          EV_MANUAL_RESET = 0;
  localparam int          EV_BATTERY_POR  = 1;
  localparam int          EV_CFG_SET      = 2;

  localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

endpackage

// *** rtc_trim_status_backup_regs.sv ***
// Operation
// - Six-bit oscillator trim, resets to 0x27.
// - Config-valid flag: writing one sets, zero keeps.
// - Manual reset or battery POR clears flag.
// - Two plain eight-bit scratch bytes, reset zero.
// - Scratch bytes hold while supply rail is up.
// - Only full reset restores reset values.
//
// This file holds the RTC trim, config-valid and scratch register bank behind AHB-Lite.
// It assumes rst_n_in is the full reset of the always-on domain and event pins are asynchronous.
`timescale 1ns/1ps

module rtc_trim_status_backup_regs #(
  parameter int ADDR_WIDTH = 12
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  hsel_in,
  input  wire logic [ADDR_WIDTH-1:0] haddr_in,
  input  wire logic [1:0]            htrans_in,
  input  wire logic                  hwrite_in,
  input  wire logic [2:0]            hsize_in,
  input  wire logic [31:0]           hwdata_in,
  input  wire logic                  hready_in,
  output logic      [31:0]           hrdata_out,
  output logic                       hreadyout_out,
  output logic                       hresp_out,
  input  wire logic                  manual_reset_in,
  input  wire logic                  battery_por_in,
  output logic      [5:0]            osc_resistance_value_out,
  output logic                       rtc_config_valid_out,
  output logic                       irq_out
);

  logic [5:0]            osc_resistance_trim_reg;
  logic                  rtc_config_valid_reg;
  logic [7:0]            backup_scratch_one_reg;
  logic [7:0]            backup_scratch_two_reg;
  logic [2:0]            irq_status_reg;
  logic [2:0]            irq_mask_reg;
  logic                  wr_pending_reg;
  logic                  rd_pending_reg;
  logic [7:0]            index_reg;
  logic [1:0]            manual_sync_reg;
  logic [1:0]            por_sync_reg;
  logic                  manual_prev_reg;
  logic                  por_prev_reg;
  logic                  manual_event;
  logic                  por_event;
  logic                  clear_event;
  logic                  cfg_set_event;
  logic                  addr_phase;
  logic [7:0]            addr_index;
  logic                  write_trim;
  logic                  write_cfg;
  logic                  write_one;
  logic                  write_two;
  logic                  read_status;
  logic [2:0]            event_vector;
  logic [31:0]           rdata_next;

  // Address phase is taken on a selected NONSEQ or SEQ transfer while the bus is ready.
  assign addr_phase = hsel_in && htrans_in[1] && hready_in;
  assign addr_index = 8'(haddr_in[ADDR_WIDTH-1:2]);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pending_reg <= 1'b0;
      rd_pending_reg <= 1'b0;
      index_reg      <= 8'h00;
    end else if (hready_in) begin
      wr_pending_reg <= addr_phase && hwrite_in;
      rd_pending_reg <= addr_phase && !hwrite_in;
      index_reg      <= addr_index;
    end
  end

  // The slave never stalls and always answers OKAY.
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  assign write_trim = wr_pending_reg && (index_reg == rtc_backup_pkg::TRIM_IDX);
  assign write_cfg  = wr_pending_reg && (index_reg == rtc_backup_pkg::CFG_VALID_IDX);
  assign write_one  = wr_pending_reg && (index_reg == rtc_backup_pkg::SCRATCH_ONE_IDX);
  assign write_two  = wr_pending_reg && (index_reg == rtc_backup_pkg::SCRATCH_TWO_IDX);
  assign read_status = addr_phase && !hwrite_in
                       && (addr_index == rtc_backup_pkg::IRQ_STATUS_IDX);

  // Event pins come from outside the clock domain and pass two flip-flops first.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      manual_sync_reg <= 2'b00;
      por_sync_reg    <= 2'b00;
      manual_prev_reg <= 1'b0;
      por_prev_reg    <= 1'b0;
    end else begin
      manual_sync_reg <= {manual_sync_reg[0], manual_reset_in};
      por_sync_reg    <= {por_sync_reg[0], battery_por_in};
      manual_prev_reg <= manual_sync_reg[1];
      por_prev_reg    <= por_sync_reg[1];
    end
  end

  assign manual_event  = manual_sync_reg[1] && !manual_prev_reg;
  assign por_event     = por_sync_reg[1] && !por_prev_reg;
  assign clear_event   = manual_sync_reg[1] || por_sync_reg[1];
  assign cfg_set_event = write_cfg && hwdata_in[rtc_backup_pkg::CFG_VALID_BIT]
                         && !rtc_config_valid_reg && !clear_event;

  // Only the full reset returns the bank to its reset values.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osc_resistance_trim_reg <= rtc_backup_pkg::TRIM_RESET;
    end else if (write_trim) begin
      osc_resistance_trim_reg <= hwdata_in[rtc_backup_pkg::TRIM_WIDTH-1:0];
    end
  end

  // The reset request holds the flag clear and wins over a software set.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rtc_config_valid_reg <= rtc_backup_pkg::CFG_RESET;
    end else if (clear_event) begin
      rtc_config_valid_reg <= 1'b0;
    end else if (write_cfg && hwdata_in[rtc_backup_pkg::CFG_VALID_BIT]) begin
      rtc_config_valid_reg <= 1'b1;
    end
  end

  // Scratch bytes are kept across host power-down; nothing but a write or the full reset changes them.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      backup_scratch_one_reg <= rtc_backup_pkg::SCRATCH_RESET;
      backup_scratch_two_reg <= rtc_backup_pkg::SCRATCH_RESET;
    end else begin
      if (write_one) begin
        backup_scratch_one_reg <= hwdata_in[rtc_backup_pkg::SCRATCH_WIDTH-1:0];
      end
      if (write_two) begin
        backup_scratch_two_reg <= hwdata_in[rtc_backup_pkg::SCRATCH_WIDTH-1:0];
      end
    end
  end

  assign event_vector = {cfg_set_event, por_event, manual_event};

  // Sticky status cleared by a read; a new event in the same cycle wins.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_status_reg <= rtc_backup_pkg::IRQ_RESET;
    end else if (read_status) begin
      irq_status_reg <= event_vector;
    end else begin
      irq_status_reg <= irq_status_reg | event_vector;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_mask_reg <= rtc_backup_pkg::IRQ_RESET;
    end else if (wr_pending_reg && (index_reg == rtc_backup_pkg::IRQ_MASK_IDX)) begin
      irq_mask_reg <= hwdata_in[rtc_backup_pkg::EVENT_COUNT-1:0];
    end
  end

  assign irq_out = |(irq_status_reg & irq_mask_reg);

  // Read data is registered at the address phase; unused bits read as zero.
  always_comb begin
    rdata_next = rtc_backup_pkg::READ_ZERO;
    unique case (addr_index)
      rtc_backup_pkg::TRIM_IDX: begin
        rdata_next[5:0] = osc_resistance_trim_reg;
      end
      rtc_backup_pkg::CFG_VALID_IDX: begin
        rdata_next[0] = rtc_config_valid_reg;
      end
      rtc_backup_pkg::SCRATCH_ONE_IDX: begin
        rdata_next[7:0] = backup_scratch_one_reg;
      end
      rtc_backup_pkg::SCRATCH_TWO_IDX: begin
        rdata_next[7:0] = backup_scratch_two_reg;
      end
      rtc_backup_pkg::IRQ_STATUS_IDX: begin
        rdata_next[2:0] = irq_status_reg;
      end
      rtc_backup_pkg::IRQ_MASK_IDX: begin
        rdata_next[2:0] = irq_mask_reg;
      end
      default: begin
        rdata_next = rtc_backup_pkg::READ_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hrdata_out <= rtc_backup_pkg::READ_ZERO;
    end else if (addr_phase && !hwrite_in) begin
      hrdata_out <= rdata_next;
    end
  end

  assign osc_resistance_value_out = osc_resistance_trim_reg;
  assign rtc_config_valid_out     = rtc_config_valid_reg;

  a_trim_reset_value: assert property (@(posedge clk_in)
    $rose(rst_n_in) |-> osc_resistance_trim_reg == rtc_backup_pkg::TRIM_RESET)
    else $error("Trim did not start at its reset value.");

  a_trim_write_lands: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    write_trim |=> osc_resistance_trim_reg == $past(hwdata_in[5:0]))
    else $error("Trim write did not take effect.");

  a_cfg_zero_keeps: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (write_cfg && !hwdata_in[0] && !clear_event) |=> $stable(rtc_config_valid_reg))
    else $error("Writing zero changed the config-valid flag.");

  a_cfg_one_sets: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (write_cfg && hwdata_in[0] && !clear_event) |=> rtc_config_valid_reg)
    else $error("Writing one did not set the config-valid flag.");

  a_cfg_clear_event: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(manual_sync_reg[1]) || $rose(por_sync_reg[1]) |=> !rtc_config_valid_reg)
    else $error("Reset event did not clear the config-valid flag.");

  a_scratch_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !write_one ##1 !write_one |-> $stable(backup_scratch_one_reg))
    else $error("Scratch byte one changed without a write.");

  a_scratch_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    write_two |=> backup_scratch_two_reg == $past(hwdata_in[7:0]))
    else $error("Scratch byte two write did not take effect.");

  a_upper_bits_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (addr_phase && !hwrite_in && addr_index == rtc_backup_pkg::CFG_VALID_IDX)
    |=> hrdata_out[31:1] == 31'h0000_0000)
    else $error("Unused config-valid bits did not read as zero.");

  a_scratch_reset: assert property (@(posedge clk_in)
    $rose(rst_n_in) |-> backup_scratch_one_reg == 8'h00 && !rtc_config_valid_reg)
    else $error("Full reset did not restore the bank.");

  a_trim_holds_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !write_trim |=> $stable(osc_resistance_trim_reg))
    else $error("Trim changed without a write.");

  // Read data in each data phase matches the register at its address phase.
  a_trim_read_data: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_pending_reg && index_reg == rtc_backup_pkg::TRIM_IDX)
    |-> hrdata_out == {26'h000_0000, $past(osc_resistance_trim_reg)})
    else $error("Trim read data was wrong.");

  a_cfg_read_data: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_pending_reg && index_reg == rtc_backup_pkg::CFG_VALID_IDX)
    |-> hrdata_out == {31'h0000_0000, $past(rtc_config_valid_reg)})
    else $error("Config-valid read data was wrong.");

  a_scratch_one_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_pending_reg && index_reg == rtc_backup_pkg::SCRATCH_ONE_IDX)
    |-> hrdata_out == {24'h00_0000, $past(backup_scratch_one_reg)})
    else $error("Scratch byte one read data was wrong.");

  a_scratch_two_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_pending_reg && index_reg == rtc_backup_pkg::SCRATCH_TWO_IDX)
    |-> hrdata_out == {24'h00_0000, $past(backup_scratch_two_reg)})
    else $error("Scratch byte two read data was wrong.");

  a_status_read_data: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_pending_reg && index_reg == rtc_backup_pkg::IRQ_STATUS_IDX)
    |-> hrdata_out == {29'h0000_0000, $past(irq_status_reg)})
    else $error("Status read data was wrong.");

  a_mask_read_data: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_pending_reg && index_reg == rtc_backup_pkg::IRQ_MASK_IDX)
    |-> hrdata_out == {29'h0000_0000, $past(irq_mask_reg)})
    else $error("Mask read data was wrong.");

  a_cfg_clear_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clear_event |=> !rtc_config_valid_reg)
    else $error("Config-valid flag set while a reset request was active.");

  a_cfg_no_fall: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !clear_event |=> !$fell(rtc_config_valid_reg))
    else $error("Config-valid flag fell without a reset request.");

  a_cfg_rise_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(rtc_config_valid_reg) |-> $past(write_cfg) && $past(hwdata_in[0]))
    else $error("Config-valid flag rose without a write of one.");

  a_scratch_one_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    write_one |=> backup_scratch_one_reg == $past(hwdata_in[7:0]))
    else $error("Scratch byte one write did not take effect.");

  a_scratch_two_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !write_two |=> $stable(backup_scratch_two_reg))
    else $error("Scratch byte two changed without a write.");

  // Status bits follow their events and clear only on a read.
  a_status_read_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    read_status |=> irq_status_reg == $past(event_vector))
    else $error("Status read did not clear the sticky bits.");

  a_status_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !read_status |=> (irq_status_reg & $past(irq_status_reg)) == $past(irq_status_reg))
    else $error("Status bit cleared without a read.");

  a_manual_event_sets: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    manual_event |=> irq_status_reg[rtc_backup_pkg::EV_MANUAL_RESET])
    else $error("Manual reset event did not set its status bit.");

  a_por_event_sets: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    por_event |=> irq_status_reg[rtc_backup_pkg::EV_BATTERY_POR])
    else $error("Battery reset event did not set its status bit.");

  a_cfg_event_sets: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_set_event |=> irq_status_reg[rtc_backup_pkg::EV_CFG_SET] && rtc_config_valid_reg)
    else $error("Software set did not raise the flag and its status bit.");

  a_mask_write_lands: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_pending_reg && index_reg == rtc_backup_pkg::IRQ_MASK_IDX)
    |=> irq_mask_reg == $past(hwdata_in[2:0]))
    else $error("Mask write did not take effect.");

  a_manual_two_flops: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(manual_sync_reg[1]) |-> $past(manual_reset_in, 2))
    else $error("Manual reset pin was not synchronised through two stages.");

  a_por_two_flops: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(por_sync_reg[1]) |-> $past(battery_por_in, 2))
    else $error("Battery reset pin was not synchronised through two stages.");

  c_cfg_set: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(rtc_config_valid_reg));
  c_cfg_cleared: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(rtc_config_valid_reg));
  c_irq_raised: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(irq_out));
  c_scratch_write: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    write_one ##1 write_two);
  c_por_event: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    por_event);

endmodule

// *** tb.sv ***
// Self-checking bench for the RTC trim, config-valid and scratch register bank.
// Assumes an AHB-Lite slave on one clock and level-sensitive reset event pins.
`timescale 1ns/1ps

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end

module tb;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        hsel_in = 1'b0;
  logic [11:0] haddr_in = 12'h000;
  logic [1:0]  htrans_in = 2'b00;
  logic        hwrite_in = 1'b0;
  logic [2:0]  hsize_in = 3'b010;
  logic [31:0] hwdata_in = 32'h0000_0000;
  logic [31:0] hrdata_out;
  logic        hreadyout_out;
  logic        hresp_out;
  logic        manual_reset_in = 1'b0;
  logic        battery_por_in = 1'b0;
  logic [5:0]  osc_resistance_value_out;
  logic        rtc_config_valid_out;
  logic        irq_out;
  logic        rd_phase = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] exp_v;
  logic [15:0] rnd = 16'h5190;
  logic [31:0] d1;
  logic [31:0] d2;
  int          error_cnt = 0;
  int          checks = 0;

  rtc_trim_status_backup_regs rtc_trim_status_backup_regs_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .manual_reset_in(manual_reset_in), .battery_por_in(battery_por_in),
    .osc_resistance_value_out(osc_resistance_value_out),
    .rtc_config_valid_out(rtc_config_valid_out), .irq_out(irq_out));

  always #12.5 clk_in = ~clk_in;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic finish_test();
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One single AHB transfer; a read notes its expected word for the watcher.
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] d);
    @(posedge clk_in);
    hsel_in   <= 1'b1;
    htrans_in <= 2'b10;
    haddr_in  <= {2'b00, idx, 2'b00};
    hwrite_in <= wr;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'b00;
    hwdata_in <= wr ? d : 32'h0000_0000;
    rd_phase  <= !wr;
    if (!wr) exp_q.push_back(d);
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    rd_phase  <= 1'b0;
    `CHK(hresp_out, 1'b0)
  endtask

  task automatic pin_pulse(input int which);
    @(posedge clk_in);
    if (which == 0) manual_reset_in <= 1'b1;
    else battery_por_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    `CHK(rtc_config_valid_out, 1'b0)
  endtask

  always @(posedge clk_in) begin
    if (rd_phase && hreadyout_out === 1'b1) begin
      exp_v = exp_q.pop_front();
      `CHK(hrdata_out, exp_v)
    end
  end

  initial begin
    #(5000 * 25);
    error_cnt++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int pass = 0; pass < 2; pass++) begin
      bus(rtc_backup_pkg::TRIM_IDX, 1'b0, 32'h0000_0027);
      bus(rtc_backup_pkg::CFG_VALID_IDX, 1'b0, 32'h0000_0000);
      bus(rtc_backup_pkg::SCRATCH_ONE_IDX, 1'b0, 32'h0000_0000);
      bus(rtc_backup_pkg::SCRATCH_TWO_IDX, 1'b0, 32'h0000_0000);
      bus(rtc_backup_pkg::IRQ_MASK_IDX, 1'b0, 32'h0000_0000);
      bus(8'h30, 1'b1, 32'hFFFF_FFFF);
      bus(8'h30, 1'b0, 32'h0000_0000);
      `CHK(osc_resistance_value_out, 6'h27)
      `CHK(irq_out, 1'b0)
      for (int i = 0; i < 3; i++) begin
        rnd = lfsr(rnd);
        d1 = {rnd, lfsr(rnd)};
        rnd = lfsr(lfsr(rnd));
        d2 = {lfsr(rnd), rnd};
        bus(rtc_backup_pkg::TRIM_IDX, 1'b1, d1);
        bus(rtc_backup_pkg::SCRATCH_ONE_IDX, 1'b1, d1);
        bus(rtc_backup_pkg::SCRATCH_TWO_IDX, 1'b1, d2);
        bus(rtc_backup_pkg::TRIM_IDX, 1'b0, {26'h0, d1[5:0]});
        bus(rtc_backup_pkg::SCRATCH_ONE_IDX, 1'b0, {24'h0, d1[7:0]});
        bus(rtc_backup_pkg::SCRATCH_TWO_IDX, 1'b0, {24'h0, d2[7:0]});
        `CHK(osc_resistance_value_out, d1[5:0])
      end
      bus(rtc_backup_pkg::CFG_VALID_IDX, 1'b1, 32'h0000_0000);
      bus(rtc_backup_pkg::CFG_VALID_IDX, 1'b0, 32'h0000_0000);
      bus(rtc_backup_pkg::CFG_VALID_IDX, 1'b1, 32'hFFFF_FFFF);
      bus(rtc_backup_pkg::CFG_VALID_IDX, 1'b1, 32'h0000_0000);
      bus(rtc_backup_pkg::CFG_VALID_IDX, 1'b0, 32'h0000_0001);
      bus(rtc_backup_pkg::IRQ_MASK_IDX, 1'b1, 32'h0000_0007);
      bus(rtc_backup_pkg::IRQ_MASK_IDX, 1'b0, 32'h0000_0007);
      `CHK(irq_out, 1'b1)
      bus(rtc_backup_pkg::IRQ_STATUS_IDX, 1'b0, 32'h0000_0004);
      bus(rtc_backup_pkg::IRQ_STATUS_IDX, 1'b0, 32'h0000_0000);
      `CHK(irq_out, 1'b0)
      pin_pulse(0);
      `CHK(irq_out, 1'b1)
      bus(rtc_backup_pkg::CFG_VALID_IDX, 1'b1, 32'h0000_0001);
      bus(rtc_backup_pkg::CFG_VALID_IDX, 1'b0, 32'h0000_0000);
      manual_reset_in <= 1'b0;
      bus(rtc_backup_pkg::IRQ_STATUS_IDX, 1'b0, 32'h0000_0001);
      bus(rtc_backup_pkg::IRQ_MASK_IDX, 1'b1, 32'h0000_0000);
      bus(rtc_backup_pkg::CFG_VALID_IDX, 1'b1, 32'h0000_0001);
      pin_pulse(1);
      `CHK(irq_out, 1'b0)
      battery_por_in <= 1'b0;
      bus(rtc_backup_pkg::IRQ_STATUS_IDX, 1'b0, 32'h0000_0006);
      bus(rtc_backup_pkg::SCRATCH_ONE_IDX, 1'b0, {24'h0, d1[7:0]});
      bus(rtc_backup_pkg::SCRATCH_TWO_IDX, 1'b0, {24'h0, d2[7:0]});
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
    end
    finish_test();
  end
endmodule
